//--- bench/drc_default_return_props.sv
// Purpose: port checks for the default/return decoder
// Assumes: sync active-low reset
// Notes:   bound to every instance
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_default_return_props
   import drc_pkg::*;
(
   input wire logic      core_clk,
   input wire logic      rst_n,
   input wire logic      csPin_n,
   input wire logic      auxClrPin_n,
   input wire logic      auxGatePin_n,
   input drc_code_t      outCode,
   input drc_dsel_e      defaultSelect,
   input drc_code_t      returnCode,
   input wire logic      gateActive,
   input wire logic      setupDone
);
   int unsigned upCnt;
   always_ff @(posedge core_clk) upCnt <= !rst_n ? 0 : (upCnt < 5000 ? upCnt + 1 : upCnt);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ====
   // properties
   a_reset_zero: assert property (disable iff (1'b0) !rst_n |=>
      outCode == 0 && returnCode == 0 && defaultSelect == DRC_DSEL_POR && !setupDone) else $error("reset state");
   a_sel_legal: assert property (defaultSelect <= 3'h4) else $error("bad selection");
   a_quiet_hold: assert property (csPin_n[*8] |=> $stable(returnCode) && $stable(defaultSelect))
      else $error("state moved without frame");
   a_gate_ret: assert property ((!auxGatePin_n && defaultSelect == DRC_DSEL_RET && $stable(returnCode))[*6]
      |-> outCode == returnCode) else $error("gate not at return");
   a_clr_ret: assert property ((!auxClrPin_n && defaultSelect == DRC_DSEL_RET && $stable(returnCode))[*6]
      |-> outCode == returnCode) else $error("clear not at return");
   a_gate_mid: assert property ((!auxGatePin_n && defaultSelect == DRC_DSEL_MID)[*6]
      |-> outCode == `DRC_CODE_MID) else $error("gate not at mid");
   a_gate_full: assert property ((!auxGatePin_n && defaultSelect == DRC_DSEL_FULL)[*6]
      |-> outCode == `DRC_CODE_FULL) else $error("gate not at full");
   a_gate_zero: assert property ((!auxGatePin_n && defaultSelect inside {DRC_DSEL_POR, DRC_DSEL_ZERO})[*6]
      |-> outCode == 0) else $error("gate not at zero");
   a_gate_flag: assert property ((!auxGatePin_n)[*6] |-> gateActive) else $error("gate flag low");
   a_setup_early: assert property (setupDone |-> upCnt >= 3990) else $error("setup too soon");
   a_setup_late: assert property (upCnt >= 4010 |-> setupDone) else $error("setup too late");
endmodule
bind drc_default_return drc_default_return_props i_props (.core_clk(core_clk), .rst_n(rst_n), .csPin_n(csPin_n),
   .auxClrPin_n(auxClrPin_n), .auxGatePin_n(auxGatePin_n), .outCode(outCode), .defaultSelect(defaultSelect),
   .returnCode(returnCode), .gateActive(gateActive), .setupDone(setupDone));

//--- bench/drc_host_model.sv
// Purpose: host sending 24-bit frames, msb first
// Assumes: link clock 400 ns, idle low between frames
// Notes:   data line shows inverse of last bit when idle
`timescale 1ns/1ps
module drc_host_model (
   input wire logic  clk,
   output logic      sclkPin,
   output logic      csPin_n,
   output logic      dinPin
);
   initial begin
      sclkPin = 1'b0;
      csPin_n = 1'b1;
      dinPin  = 1'b0;
   end
   // ====
   // frame: data formatted like code/load words
   task automatic send(input logic [23:0] f);
      csPin_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         repeat (4) @(posedge clk);
         sclkPin <= 1'b0;
         dinPin  <= f[i];
         repeat (4) @(posedge clk);
         sclkPin <= 1'b1;
      end
      repeat (4) @(posedge clk);
      sclkPin <= 1'b0;
      csPin_n <= 1'b1;
      dinPin  <= ~f[0];
      repeat (6) @(posedge clk);
   endtask
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench for the default/return decoder
// Assumes: 50 ns clock, host model drives the link
// Notes:   fixed waits cover pin-to-output latency
`timescale 1ns/1ps
module tb;
   import drc_pkg::*;
   logic      core_clk, rst_n, sclkPin, csPin_n, dinPin, auxClrPin_n, auxGatePin_n, gateActive, setupDone;
   drc_code_t outCode, returnCode;
   drc_dsel_e defaultSelect;
   int        err_count = 0;
   int        n_tests = 0;
   int        cyc = 0;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
   drc_host_model i_drc_host_model (.clk(core_clk), .sclkPin(sclkPin), .csPin_n(csPin_n), .dinPin(dinPin));
   drc_default_return i_drc_default_return (.core_clk(core_clk), .rst_n(rst_n), .sclkPin(sclkPin),
      .csPin_n(csPin_n), .dinPin(dinPin), .auxClrPin_n(auxClrPin_n), .auxGatePin_n(auxGatePin_n),
      .outCode(outCode), .defaultSelect(defaultSelect), .returnCode(returnCode), .gateActive(gateActive),
      .setupDone(setupDone));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= rst_n ? cyc + 1 : 0;
   // ====
   // helpers
   task automatic tick(input int n); repeat (n) @(posedge core_clk); endtask
   task automatic frame(input logic [23:0] f); i_drc_host_model.send(f); tick(8); endtask
   task automatic pin(input logic g, input logic c); auxGatePin_n <= g; auxClrPin_n <= c; tick(8); endtask
   task automatic stop_test;
      $display("errors %0d of %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ====
   // scenarios
   task automatic t_select;
      drc_code_t exp [5];
      exp = '{12'h000, 12'h000, 12'h800, 12'hfff, 12'habc};
      frame({4'h7, 4'hf, 12'habc, 4'hf});
      `CHK("returnCode", 12'habc, returnCode)
      frame({4'h8, 4'h0, 12'h123, 4'h0});
      for (int s = 0; s < 5; s++) begin
         frame({4'h6, 12'hfff, s[2:0], 5'h1f});
         `CHK("defaultSelect", s[2:0], defaultSelect)
         pin(1'b0, 1'b1);
         `CHK("gated outCode", exp[s], outCode)
         `CHK("gateActive", 1'b1, gateActive)
         pin(1'b1, 1'b1);
         `CHK("released outCode", 12'h123, outCode)
      end
      frame({4'h6, 12'h000, 3'h5, 5'h00});
      `CHK("kept selection", DRC_DSEL_RET, defaultSelect)
   endtask
   task automatic t_clear;
      pin(1'b1, 1'b0);
      `CHK("cleared outCode", 12'habc, outCode)
      pin(1'b1, 1'b1);
      `CHK("code after clear", 12'habc, outCode)
      frame({4'h8, 4'h0, 12'h456, 4'h0});
      frame({4'h3, 4'h1, 16'h0000});
      `CHK("sw gate outCode", 12'habc, outCode)
      frame({4'h3, 4'h0, 16'h0000});
      `CHK("gate end outCode", 12'h456, outCode)
      frame({4'h3, 4'h4, 16'h0000});
      `CHK("sw clear outCode", 12'habc, outCode)
   endtask
   task automatic t_soft;
      frame({4'h3, 4'h5, 16'hffff});
      `CHK("soft outCode", 12'h000, outCode)
      `CHK("soft selection", DRC_DSEL_POR, defaultSelect)
      `CHK("soft returnCode", 12'h000, returnCode)
      while (!setupDone && cyc < 6000) tick(1); // host waits out setup
      `CHK("setup span", 1'b1, cyc >= 4000 && cyc < 4020)
   endtask
   initial begin
      rst_n = 1'b0;
      auxClrPin_n = 1'b1;
      auxGatePin_n = 1'b1;
      tick(12);
      rst_n <= 1'b1;
      tick(1);
      `CHK("reset outCode", 12'h000, outCode)
      `CHK("reset returnCode", 12'h000, returnCode)
      t_select;
      t_clear;
      t_soft;
      stop_test;
   end
   initial begin
      tick(20000);
      err_count++;
      stop_test;
   end
endmodule

//--- hw/drc_default_return.sv
// Purpose: default-select and return commands, clear/gate fallback, power-on zero
// Assumes: 12-bit code, left justified in b15..b4 like the code/load commands
// Notes:   aux clear/gate pin is active low and asynchronous, so it is synchronised
`timescale 1ns/1ps
`include "drc_defs.svh"
// Contract
// R1 - opcode 0110 takes default selection from bits 7..5, other bits ignored
// R2 - opcode 0111 writes frame data field into the return register
// R3 - with return selected, clear or gate drives output to return value
// R4 - return data placed and justified exactly like code/load data
// R5 - power-up sets output code to zero scale
// R6 - host waits about 200 us after power before relying on linearity
// R7 - selection codes 000..100 valid; other codes keep current selection
// R8 - software reset or supply cycle returns output to zero, ignores selection
// R9 - stored selection applies to every later clear and gate
// R10 - selection resets to power-on choice and return register to zero
module drc_default_return (
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   input  wire logic               sclkPin,
   input  wire logic               csPin_n,
   input  wire logic               dinPin,
   input  wire logic               auxClrPin_n,
   input  wire logic               auxGatePin_n,
   output drc_pkg::drc_code_t      outCode,
   output drc_pkg::drc_dsel_e      defaultSelect,
   output drc_pkg::drc_code_t      returnCode,
   output logic                    gateActive,
   output logic                    setupDone
);
   import drc_pkg::*;

   localparam int SETUP_CYC = (`DRC_SETUP_NS + `DRC_CLK_NS - 1) / `DRC_CLK_NS;
   localparam int SETUP_W   = $clog2(SETUP_CYC + 1);

   // ==========================================================
   // frame receive
   logic [`DRC_FRAME_W-1:0] frame;
   logic                    frameValid;

   drc_frame_rx uRx (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .sclkPin    (sclkPin),
      .csPin_n    (csPin_n),
      .dinPin     (dinPin),
      .frameData  (frame),
      .frameValid (frameValid)
   );

   // ==========================================================
   // decode
   function automatic logic isOp(input logic [`DRC_FRAME_W-1:0] f, input logic [3:0] op);
      isOp = (f[`DRC_OP_HI:`DRC_OP_LO] == op);
   endfunction

   logic [2:0] dselField;
   logic [2:0] swField;
   drc_code_t  dataField;
   logic       cmdDefault;
   logic       cmdReturn;
   logic       cmdCode;
   logic       cmdSoft;
   logic       dselValid;
   logic       swReset;
   logic       swClear;
   logic       swGate;
   logic       swEnd;

   assign dselField  = frame[`DRC_DSEL_HI:`DRC_DSEL_LO];                  // [R1]
   assign dataField  = frame[`DRC_DATA_HI:`DRC_DATA_LO];                  // [R4]
   assign swField    = frame[`DRC_SW_HI:`DRC_SW_LO];
   assign cmdDefault = frameValid & isOp(frame, `DRC_OP_DEFAULT);         // [R1]
   assign cmdReturn  = frameValid & isOp(frame, `DRC_OP_RETURN);          // [R2]
   assign cmdCode    = frameValid & isOp(frame, `DRC_OP_CODE);
   assign cmdSoft    = frameValid & isOp(frame, `DRC_OP_SOFT);
   assign dselValid  = (dselField <= DRC_DSEL_RET);                       // [R7]
   assign swReset    = cmdSoft & (swField == `DRC_SW_RESET);
   assign swClear    = cmdSoft & (swField == `DRC_SW_CLEAR);
   assign swGate     = cmdSoft & (swField == `DRC_SW_GATE);
   assign swEnd      = cmdSoft & (swField == `DRC_SW_END);

   // ==========================================================
   // aux pins
   logic [1:0] clrSync_ff;
   logic [1:0] gateSync_ff;
   logic       hwClear;
   logic       hwGate;

   always_ff @(posedge core_clk) begin
      clrSync_ff  <= {clrSync_ff[0], auxClrPin_n};
      gateSync_ff <= {gateSync_ff[0], auxGatePin_n};
   end

   assign hwClear = ~clrSync_ff[1];
   assign hwGate  = ~gateSync_ff[1];

   // ==========================================================
   // default selection and return register
   drc_dsel_e dsel_ff;
   drc_code_t ret_ff;
   drc_code_t code_ff;
   logic      swGate_ff;
   drc_code_t fallback;

   always_ff @(posedge core_clk) begin
      if (!rst_n || swReset) begin
         dsel_ff <= DRC_DSEL_POR;                                         // [R10] [R8]
         ret_ff  <= `DRC_CODE_ZERO;                                       // [R10]
      end else begin
         if (cmdDefault && dselValid) begin
            dsel_ff <= drc_dsel_e'(dselField);                            // [R1] [R7] [R9]
         end
         if (cmdReturn) begin
            ret_ff <= dataField;                                          // [R2] [R4]
         end
      end
   end

   // power-on choice is zero scale, so por and zero coincide
   assign fallback = (dsel_ff == DRC_DSEL_RET)  ? ret_ff :                // [R3] [R9]
                     (dsel_ff == DRC_DSEL_MID)  ? `DRC_CODE_MID :
                     (dsel_ff == DRC_DSEL_FULL) ? `DRC_CODE_FULL :
                     `DRC_CODE_ZERO;

   // ==========================================================
   // output code, clear and gate
   always_ff @(posedge core_clk) begin
      if (!rst_n || swReset) begin
         code_ff   <= `DRC_CODE_ZERO;                                     // [R5] [R8]
         swGate_ff <= 1'b0;
      end else begin
         if (swClear || hwClear) begin
            code_ff <= fallback;                                          // [R3]
         end else if (cmdCode) begin
            code_ff <= dataField;
         end
         if (swGate) begin
            swGate_ff <= 1'b1;
         end else if (swEnd) begin
            swGate_ff <= 1'b0;
         end
      end
   end

   // gate overrides the held code only while active; code is kept underneath
   logic      gateNow;
   drc_code_t nxt_out;
   drc_code_t out_ff;
   logic      gate_ff;
   assign gateNow = swGate_ff | hwGate;
   assign nxt_out = gateNow ? fallback : code_ff;                         // [R3]

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_ff  <= `DRC_CODE_ZERO;                                       // [R5]
         gate_ff <= 1'b0;
      end else begin
         out_ff  <= nxt_out;
         gate_ff <= gateNow;
      end
   end

   // ==========================================================
   // setup settle indicator, a guide for the host only
   logic [SETUP_W-1:0] setupCnt_ff;
   logic               setup_ff;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         setupCnt_ff <= '0;
         setup_ff    <= 1'b0;
      end else if (!setup_ff) begin
         setupCnt_ff <= setupCnt_ff + SETUP_W'(1);
         setup_ff    <= (setupCnt_ff == SETUP_W'(SETUP_CYC - 1));          // [R6]
      end
   end

   assign outCode       = out_ff;
   assign defaultSelect = dsel_ff;
   assign returnCode    = ret_ff;
   assign gateActive    = gate_ff;
   assign setupDone     = setup_ff;
endmodule

//--- hw/drc_defs.svh
// Purpose: named constants for the default/return command decoder
// Assumes: 24-bit frames, msb first, 12-bit output code
// Notes:   included by the package and the design modules
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_FRAME_W      24
`define DRC_CNT_W        5
`define DRC_CODE_W       12
`define DRC_OP_HI        23
`define DRC_OP_LO        20
`define DRC_DATA_HI      15
`define DRC_DATA_LO      4
`define DRC_DSEL_HI      7
`define DRC_DSEL_LO      5
`define DRC_OP_DEFAULT   4'h6
`define DRC_OP_RETURN    4'h7
`define DRC_OP_CODE      4'h8
`define DRC_OP_SOFT      4'h3
`define DRC_SW_HI        18
`define DRC_SW_LO        16
`define DRC_SW_END       3'h0
`define DRC_SW_GATE      3'h1
`define DRC_SW_CLEAR     3'h4
`define DRC_SW_RESET     3'h5
`define DRC_CODE_ZERO    12'h000
`define DRC_CODE_MID     12'h800
`define DRC_CODE_FULL    12'hfff
`define DRC_LAST_BIT     5'h17
`define DRC_SETUP_NS     200000
`define DRC_CLK_NS       50
`endif

//--- hw/drc_frame_rx.sv
// Purpose: serial frame receiver sampled on core_clk
// Assumes: link clock well below core_clk/4; data sampled on link rising edge
// Notes:   all pins pass two flops before use
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_frame_rx (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic                     sclkPin,
   input  wire logic                     csPin_n,
   input  wire logic                     dinPin,
   output logic      [`DRC_FRAME_W-1:0]  frameData,
   output logic                          frameValid
);
   logic [1:0] sclkSync_ff;
   logic [1:0] csSync_ff;
   logic [1:0] dinSync_ff;
   logic       sclkLast_ff;
   logic [`DRC_FRAME_W-1:0] shift_ff;
   logic [`DRC_CNT_W-1:0]   count_ff;
   logic       sclkRise;
   logic       frameDone;
   logic [`DRC_FRAME_W-1:0] nxt_shift;

   assign sclkRise  = sclkSync_ff[1] & ~sclkLast_ff;
   assign nxt_shift = {shift_ff[`DRC_FRAME_W-2:0], dinSync_ff[1]};
   // the 24th bit completes a frame; extra bits before cs rises are dropped
   assign frameDone = sclkRise & ~csSync_ff[1] & (count_ff == `DRC_LAST_BIT);

   always_ff @(posedge core_clk) begin
      sclkSync_ff <= {sclkSync_ff[0], sclkPin};
      csSync_ff   <= {csSync_ff[0], csPin_n};
      dinSync_ff  <= {dinSync_ff[0], dinPin};
      sclkLast_ff <= sclkSync_ff[1];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || csSync_ff[1]) begin
         shift_ff <= '0;
         count_ff <= '0;
      end else if (sclkRise && count_ff <= `DRC_LAST_BIT) begin
         shift_ff <= nxt_shift;
         count_ff <= count_ff + 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         frameData  <= '0;
         frameValid <= 1'b0;
      end else begin
         frameValid <= frameDone;
         if (frameDone) begin
            frameData <= nxt_shift;
         end
      end
   end
endmodule

//--- hw/drc_pkg.sv
// Purpose: types for the default/return command decoder
// Assumes: constants come from drc_defs.svh
// Notes:   default selection encoding is the frame field encoding
`include "drc_defs.svh"
package drc_pkg;
   typedef enum logic [2:0] {
      DRC_DSEL_POR  = 3'h0,
      DRC_DSEL_ZERO = 3'h1,
      DRC_DSEL_MID  = 3'h2,
      DRC_DSEL_FULL = 3'h3,
      DRC_DSEL_RET  = 3'h4
   } drc_dsel_e;
   typedef logic [`DRC_CODE_W-1:0] drc_code_t;
endpackage
